// [hdl/pccr_consts.svh]
/*
  Constants of the phy configuration and control register bank: register
  offsets, field positions, reset values and cycle counts.
  Assumes it is included by bare name from design files only.
*/
`ifndef PCCR_CONSTS_SVH
`define PCCR_CONSTS_SVH

// register offsets printed as indices; byte address is four times the index
`define PCCR_IDX_CONFIG_THREE   8'h1E
`define PCCR_IDX_DEV_RESET_CTRL 8'h1F
`define PCCR_IDX_TEST_CHANNEL   8'h25
`define PCCR_IDX_IRQ_STATUS     8'h30
`define PCCR_IDX_IRQ_MASK       8'h31
`define PCCR_IDX_PHY_STATUS     8'h32

// config_three fields
`define PCCR_BIT_EXT_FD         11
`define PCCR_BIT_ROBUST_MDIX    9
`define PCCR_BIT_FAST_MDIX      8
`define PCCR_BIT_IRQ_OE         7
`define PCCR_BIT_FORCE_IRQ      6
`define PCCR_BIT_TEST_FAILED    2
`define PCCR_BIT_TEST_COMPLETE  1
`define PCCR_BIT_TEST_BEGIN     0
`define PCCR_CONFIG_THREE_RW_MASK       16'h0BC1
`define PCCR_CONFIG_THREE_RESET         16'h0002

// device_reset_control fields
`define PCCR_BIT_FULL_RESET     15
`define PCCR_BIT_KEEP_RESET     14

// test_channel_control fields; upper reserved byte reads its default
`define PCCR_BIT_ALL_CHANNELS   7
`define PCCR_TCH_SEL_HI         6
`define PCCR_TCH_SEL_LO         5
`define PCCR_TCH_RESET          16'h0400
`define PCCR_TCH_RW_MASK        16'h00E0

// interrupt status bits
`define PCCR_IRQ_TEST_DONE      0
`define PCCR_IRQ_TEST_FAIL      1
`define PCCR_IRQ_RESTART        2
`define PCCR_IRQ_WIDTH          3

// length of the operating reset pulse, in ns, and the cycles it takes
`define PCCR_CLK_PERIOD_NS      4
`define PCCR_RESTART_NS         40
`define PCCR_RESTART_CYCLES     (`PCCR_RESTART_NS / `PCCR_CLK_PERIOD_NS)

`endif

// [hdl/pccr_pkg.sv]
/*
  Types of the phy configuration and control register bank.
  Assumes nothing beyond a SystemVerilog tool.
*/
package pccr_pkg;
  typedef enum logic [1:0] {
    pccr_chan_a,
    pccr_chan_b,
    pccr_chan_c,
    pccr_chan_d
  } pccr_chan_t;

  typedef enum logic [1:0] {
    pccr_tst_idle,
    pccr_tst_run,
    pccr_tst_done
  } pccr_tst_state_t;
endpackage

// [hdl/pccr_test_if.sv]
/*
  Interface carrying cable-test start, progress and result between the
  register bank and the cable test sequencer.
  Assumes both ends run on the same sys_clk.
*/
`timescale 1ns/1ps
interface pccr_test_if;
  logic start;
  logic complete;
  logic failed;
  modport bank (output start, input complete, input failed);
  modport seq  (input start, output complete, output failed);
endinterface // pccr_test_if

// [hdl/pccr_cable_test.sv]
/*
  Cable test sequencer: runs one test per start pulse, holds completion low
  while running and latches the newest outcome unless start arrives with engine_done.
  Assumes the analog engine answers with a done pulse and a fail level.
*/
`timescale 1ns/1ps
`include "pccr_consts.svh"
module pccr_cable_test (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic op_reset,
  pccr_test_if.seq  tst,
  output      logic engine_run,
  input  wire logic engine_done,
  input  wire logic engine_fail
);
  pccr_pkg::pccr_tst_state_t state;
  pccr_pkg::pccr_tst_state_t next_state;
  logic                      fail_q;

  // start is ignored while a test is running; it only starts one from idle or done
  always_comb begin
    next_state = state;
    unique case (state)
      pccr_pkg::pccr_tst_idle: if (tst.start) next_state = pccr_pkg::pccr_tst_run;
      pccr_pkg::pccr_tst_run:  if (engine_done) next_state = pccr_pkg::pccr_tst_done;
      pccr_pkg::pccr_tst_done: if (tst.start) next_state = pccr_pkg::pccr_tst_run;
      default:                 next_state = pccr_pkg::pccr_tst_idle;
    endcase
  end

  // an operating reset abandons a running test and reports it complete
  always_ff @(posedge sys_clk) begin
    if (!reset_n || op_reset) begin
      state  <= pccr_pkg::pccr_tst_idle;
      fail_q <= 1'b0;
    end else begin
      state <= next_state;
      if (tst.start) fail_q <= 1'b0;
      else if (state == pccr_pkg::pccr_tst_run && engine_done) fail_q <= engine_fail;
    end
  end

  assign tst.complete = (state != pccr_pkg::pccr_tst_run);
  assign tst.failed   = fail_q;
  assign engine_run   = (state == pccr_pkg::pccr_tst_run);
endmodule // pccr_cable_test

// [hdl/pccr_chan_decode.sv]
/*
  Test mode channel decode: turns the channel choice into one enable per
  media channel.
  Assumes a registered choice on the same clock.
*/
`timescale 1ns/1ps
module pccr_chan_decode #(
  parameter int N_CHAN = 4
) (
  input  wire logic              all_channels,
  input  wire logic [1:0]        test_channel_choice,
  output      logic [N_CHAN-1:0] chan_enable
);
  // one compare per channel
  for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
    assign chan_enable[i] = all_channels ||
                            (test_channel_choice == 2'(i));
  end
endmodule // pccr_chan_decode

// [hdl/pccr_regs.sv]
/*
  Phy configuration and control register bank on an Avalon-MM slave:
  third configuration register, device reset control, test channel select,
  plus interrupt status and mask.
  Assumes a synchronous Avalon master on sys_clk; the pad is sampled here
  through two flip-flops; duplex and crossover logic sits outside.
*/
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pccr_consts.svh"
module pccr_regs #(
  parameter int N_CHAN = 4
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output      logic [31:0]       avs_readdata,
  output      logic [1:0]        avs_response,
  output      logic              avs_waitrequest,
  output      logic              irq,
  input  wire logic              pad_in,
  output      logic              pad_out,
  output      logic              pad_oe_n,
  output      logic              power_down,
  output      logic              ext_full_duplex,
  output      logic              robust_mdix,
  output      logic              fast_mdix,
  output      logic              op_reset,
  output      logic [N_CHAN-1:0] test_chan_enable,
  output      logic              engine_run,
  input  wire logic              engine_done,
  input  wire logic              engine_fail,
  input  wire logic              event_irq
);
  pccr_test_if tst ();

  logic [15:0] config_three;
  logic [15:0] test_channel_control;
  logic [`PCCR_IRQ_WIDTH-1:0] irq_status;
  logic [`PCCR_IRQ_WIDTH-1:0] irq_mask;
  logic        full_reset_with_regs;
  logic        reset_keep_regs;
  logic [7:0]  restart_cnt;
  logic        pad_s1;
  logic        pad_s2;
  logic        ev_s1;
  logic        ev_s2;
  logic        done_q;
  logic        fail_q;
  logic        ack;
  logic [N_CHAN-1:0] chan_en;
  logic        run_w;

  // bus decode, all by continuous assignment
  wire         access      = (avs_read || avs_write) && !ack;
  wire [7:0]   idx         = avs_address[9:2];
  wire         lo_lane     = avs_byteenable[0];
  wire         hi_lane     = avs_byteenable[1];
  wire [15:0]  lane_mask   = {{8{hi_lane}}, {8{lo_lane}}};
  // a write lands only at the edge where waitrequest is sampled low
  wire         wr          = avs_write && ack;
  wire         hit_config_three    = idx == `PCCR_IDX_CONFIG_THREE;
  wire         hit_ctrl    = idx == `PCCR_IDX_DEV_RESET_CTRL;
  wire         hit_tch     = idx == `PCCR_IDX_TEST_CHANNEL;
  wire         hit_ists    = idx == `PCCR_IDX_IRQ_STATUS;
  wire         hit_imsk    = idx == `PCCR_IDX_IRQ_MASK;
  wire         hit_psts    = idx == `PCCR_IDX_PHY_STATUS;
  wire         mapped      = hit_config_three | hit_ctrl | hit_tch | hit_ists | hit_imsk | hit_psts;
  wire [15:0]  wdata       = avs_writedata[15:0];

  // write strobes per register; status and mask use the low lane only
  wire         wr_config_three     = wr && hit_config_three;
  wire         wr_ctrl     = wr && hit_ctrl;
  wire         wr_tch      = wr && hit_tch;
  wire         wr_ists     = wr && hit_ists && lo_lane;
  wire         wr_imsk     = wr && hit_imsk && lo_lane;
  wire         begin_test  = wr_config_three && lo_lane && wdata[`PCCR_BIT_TEST_BEGIN];
  wire         full_req    = wr_ctrl && hi_lane && wdata[`PCCR_BIT_FULL_RESET];
  wire         keep_req    = wr_ctrl && hi_lane && wdata[`PCCR_BIT_KEEP_RESET];

  // full reset reloads the bank like the pin reset; the bus handshake and read data flops keep their state
  wire         regs_rst    = !reset_n || full_reset_with_regs;
  wire [15:0]  config_three_wmask  = `PCCR_CONFIG_THREE_RW_MASK & lane_mask;
  wire [15:0]  tch_wmask   = `PCCR_TCH_RW_MASK & lane_mask;

  // read view: status bits come from the sequencer, reserved bits are zero except the test channel upper byte, which reads its default
  wire [15:0]  config_three_view   = (config_three & `PCCR_CONFIG_THREE_RW_MASK)
                           | (16'(done_q) << `PCCR_BIT_TEST_COMPLETE)
                           | (16'(fail_q) << `PCCR_BIT_TEST_FAILED);
  wire [15:0]  ctrl_view   = {full_reset_with_regs, reset_keep_regs, 14'h0000};
  wire [15:0]  psts_view   = {12'h000, op_reset, run_w, pad_s2, done_q};
  wire [15:0]  rd_mux      = hit_config_three ? config_three_view :
                             hit_ctrl ? ctrl_view :
                             hit_tch  ? test_channel_control :
                             hit_ists ? 16'(irq_status) :
                             hit_imsk ? 16'(irq_mask) :
                             hit_psts ? psts_view : 16'h0000;

  // hardware events; set wins over a write-one clear in the same cycle
  wire [`PCCR_IRQ_WIDTH-1:0] ev_set;
  // test events fire on the rising edge of the sequencer's indications
  assign ev_set[`PCCR_IRQ_TEST_DONE] = tst.complete && !done_q;
  assign ev_set[`PCCR_IRQ_TEST_FAIL] = tst.failed && !fail_q;
  assign ev_set[`PCCR_IRQ_RESTART]   = ev_s2;
  wire [`PCCR_IRQ_WIDTH-1:0] ists_clr =
    wr_ists ? wdata[`PCCR_IRQ_WIDTH-1:0] : {`PCCR_IRQ_WIDTH{1'b0}};
  wire [`PCCR_IRQ_WIDTH-1:0] next_irq_status = (irq_status & ~ists_clr) | ev_set;
  wire         next_irq    = config_three[`PCCR_BIT_FORCE_IRQ]
                           || |(next_irq_status & irq_mask);
  wire         irq_oe      = config_three[`PCCR_BIT_IRQ_OE];

  assign tst.start = begin_test;

  pccr_cable_test u_test (
    .sys_clk     (sys_clk),
    .reset_n     (!regs_rst ? 1'b1 : 1'b0),
    .op_reset    (op_reset),
    .tst         (tst),
    .engine_run  (run_w),
    .engine_done (engine_done),
    .engine_fail (engine_fail)
  );

  pccr_chan_decode #(.N_CHAN(N_CHAN)) u_chan (
    .all_channels        (test_channel_control[`PCCR_BIT_ALL_CHANNELS]),
    .test_channel_choice (test_channel_control[`PCCR_TCH_SEL_HI:`PCCR_TCH_SEL_LO]),
    .chan_enable         (chan_en)
  );

  // pad synchroniser; only the second stage feeds logic
  always_ff @(posedge sys_clk) begin
    pad_s1 <= pad_in;
    pad_s2 <= pad_s1;
  end

  // event synchroniser; a level held high keeps setting its status bit
  always_ff @(posedge sys_clk) begin
    ev_s1 <= event_irq;
    ev_s2 <= ev_s1;
  end

  // third configuration register; reserved and status bits never take a write
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      config_three <= `PCCR_CONFIG_THREE_RESET;
    end else if (wr_config_three) begin
      config_three <= (config_three & ~config_three_wmask) | (wdata & config_three_wmask);
    end
  end

  // test channel select; the upper byte and bits 4:0 keep their defaults
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      test_channel_control <= `PCCR_TCH_RESET;
    end else if (wr_tch) begin
      test_channel_control <= (test_channel_control & ~tch_wmask) | (wdata & tch_wmask);
    end
  end

  // interrupt mask, low lane only
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      irq_mask <= '0;
    end else if (wr_imsk) begin
      irq_mask <= wdata[`PCCR_IRQ_WIDTH-1:0];
    end
  end

  // sticky status; next_irq_status already lets a set win over a clear
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // mirrored results; done resets high so no false event follows reset
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      done_q <= 1'b1;
      fail_q <= 1'b0;
    end else begin
      done_q <= tst.complete;
      fail_q <= tst.failed;
    end
  end

  // full reset: one-cycle pulse that clears itself as the bank reloads
  always_ff @(posedge sys_clk) begin
    if (!reset_n || full_reset_with_regs) full_reset_with_regs <= 1'b0;
    else full_reset_with_regs <= full_req;
  end

  // operating reset held a fixed count, registers untouched
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      reset_keep_regs <= 1'b0;
      restart_cnt     <= '0;
    end else if (keep_req) begin
      reset_keep_regs <= 1'b1;
      restart_cnt     <= 8'(`PCCR_RESTART_CYCLES);
    end else if (restart_cnt != 8'h00) begin
      restart_cnt     <= restart_cnt - 8'h01;
      reset_keep_regs <= (restart_cnt != 8'h01);
    end
  end

  // operating reset follows the restart pulse one cycle later
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      op_reset <= 1'b1;
    end else begin
      op_reset <= reset_keep_regs;
    end
  end

  // duplex and crossover enables for the link logic outside this bank
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      ext_full_duplex <= 1'b0;
      robust_mdix     <= 1'b0;
      fast_mdix       <= 1'b0;
    end else begin
      ext_full_duplex <= config_three[`PCCR_BIT_EXT_FD];
      robust_mdix     <= config_three[`PCCR_BIT_ROBUST_MDIX];
      fast_mdix       <= config_three[`PCCR_BIT_FAST_MDIX];
    end
  end

  // channel enables and engine run, registered so the outputs never glitch
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      test_chan_enable <= '0;
      engine_run       <= 1'b0;
    end else begin
      test_chan_enable <= chan_en;
      engine_run       <= run_w;
    end
  end

  // interrupt level and pad; the pad is released while it serves as input
  always_ff @(posedge sys_clk) begin
    if (regs_rst) begin
      irq        <= 1'b0;
      pad_out    <= 1'b1;
      pad_oe_n   <= 1'b1;
      power_down <= 1'b0;
    end else begin
      irq        <= next_irq;
      pad_out    <= !next_irq;       // pad is active low when driven
      pad_oe_n   <= !irq_oe;
      power_down <= !irq_oe && !pad_s2;
    end
  end

  // one wait state: waitrequest idles high and drops for the taking cycle,
  // so it comes from a flop and the master still sees it on the first cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ack             <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack             <= access;
      avs_waitrequest <= !access;
    end
  end

  // read data and response are captured in the first cycle and stand
  // until the next access; a write answers with zero data
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else if (access) begin
      avs_readdata <= avs_read ? {16'h0000, rd_mux} : 32'h0000_0000;
      avs_response <= mapped ? 2'b00 : 2'b11;   // decode error off the map
    end
  end
endmodule // pccr_regs

// [test/pccr_regs_sva.sv]
/*
  Checker for the register bank ports: bus answer timing, control outputs
  that follow written bits, reserved and unmapped reads, restart pulse.
  Assumes one clock and the synchronous active-low reset of the bank.
*/
`timescale 1ns/1ps
module pccr_regs_sva #(
  parameter int N_CHAN = 4
) (
  input wire logic              sys_clk,
  input wire logic              reset_n,
  input wire logic [9:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic [1:0]        avs_response,
  input wire logic              avs_waitrequest,
  input wire logic              irq,
  input wire logic              pad_oe_n,
  input wire logic              ext_full_duplex,
  input wire logic              robust_mdix,
  input wire logic              fast_mdix,
  input wire logic              op_reset,
  input wire logic [N_CHAN-1:0] test_chan_enable
);
  // taken-cycle decode; a request only counts where waitrequest is low
  wire [7:0] idx = avs_address[9:2];
  wire       wt = avs_write && !avs_waitrequest;
  wire       rt = avs_read && !avs_waitrequest;
  wire       cfg_lo = wt && idx == 8'h1E && avs_byteenable[0];
  logic [15:0] wd;

  // last taken write, so delayed checks need no local variables
  always_ff @(posedge sys_clk) begin
    if (wt)
      wd <= avs_writedata[15:0];
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low on second cycle");
  a_mdix_follow: assert property (wt && idx == 8'h1E && avs_byteenable[1] |-> ##[1:2]
    {ext_full_duplex, robust_mdix, fast_mdix} == {wd[11], wd[9:8]})
    else $error("duplex or crossover enable wrong");
  a_pad_dir: assert property (cfg_lo |-> ##[1:2] pad_oe_n == !wd[7])
    else $error("pad direction wrong");
  a_force_irq: assert property (cfg_lo && avs_writedata[6] |-> ##[1:3] irq)
    else $error("forced interrupt not seen");
  a_reserved_zero: assert property (rt && idx inside {8'h1E, 8'h1F} |->
    avs_readdata[31:16] == 16'h0 && avs_readdata[5:3] == 3'h0 &&
    (idx == 8'h1E || avs_readdata[13:0] == 14'h0))
    else $error("reserved bits not zero");
  a_restart_len: assert property (wt && idx == 8'h1F && avs_byteenable[1] &&
    avs_writedata[15:14] == 2'b01 |-> ##[1:2] op_reset [*8] ##[1:6] !op_reset)
    else $error("restart pulse length wrong");
  a_chan_sel: assert property (wt && idx == 8'h25 && avs_byteenable[0] |-> ##[1:2]
    test_chan_enable == (wd[7] ? {N_CHAN{1'b1}} : N_CHAN'(1) << wd[6:5]))
    else $error("channel enables wrong");
  a_unmapped_read: assert property (rt && !(idx inside {8'h1E, 8'h1F, 8'h25, 8'h30, 8'h31,
    8'h32}) |-> avs_response == 2'b11 && avs_readdata == 32'h0)
    else $error("unmapped read answer wrong");
endmodule // pccr_regs_sva

bind pccr_regs pccr_regs_sva #(.N_CHAN(N_CHAN)) i_pccr_regs_sva (.sys_clk, .reset_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_response, .avs_waitrequest, .irq, .pad_oe_n, .ext_full_duplex, .robust_mdix,
  .fast_mdix, .op_reset, .test_chan_enable);

// [test/pccr_regs_tb.sv]
/*
  Self-checking bench of the register bank, driven over Avalon-MM.
  Assumes the bank answers each request on its second cycle.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module pccr_regs_tb;
  logic        sys_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        pad_in = 1'b1, engine_done = 1'b0, engine_fail = 1'b0, event_irq = 1'b0;
  logic [9:0]  avs_address = 10'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'h3, test_chan_enable;
  logic [1:0]  avs_response, rsp;
  logic        avs_waitrequest, irq, pad_out, pad_oe_n, power_down, op_reset, engine_run;
  logic        ext_full_duplex, robust_mdix, fast_mdix, f;
  logic [15:0] d;
  int          failures = 0, n_tests = 0;

  always #2 sys_clk = ~sys_clk;

  pccr_regs i_pccr_regs (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response, .avs_waitrequest, .irq,
    .pad_in, .pad_out, .pad_oe_n, .power_down, .ext_full_duplex, .robust_mdix, .fast_mdix,
    .op_reset, .test_chan_enable, .engine_run, .engine_done, .engine_fail, .event_irq);

  // expected readback of config_three when no cable test is started
  function automatic logic [15:0] cfg_exp(input logic [15:0] v);
    return (v & 16'h0B80) | 16'h0002;
  endfunction

  // expected channel enables for a written choice
  function automatic logic [3:0] chan_exp(input logic [2:0] v);
    return v[2] ? 4'hF : 4'h1 << v[1:0];
  endfunction

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one bus access; held until waitrequest is sampled low, bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] dd);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= {a, 2'b00};
    avs_writedata <= {16'h0, dd};
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      failures++;
      complete_run;
    end
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    `CHK($sformatf("reg %h", a), e, rd[15:0] & m)
  endtask

  initial begin
    void'($urandom(1281));
    cyc(20);
    reset_n <= 1'b1;
    rchk(8'h1E, 16'hFFFF, 16'h0002);
    rchk(8'h1F, 16'hFFFF, 16'h0000);
    rchk(8'h25, 16'hFFFF, 16'h0400);
    `CHK("pad_oe_n", 1'b1, pad_oe_n)
    $display("done: reset values");
    // all writable bits set first, then random; start and force kept clear
    for (int i = 0; i < 9; i++) begin
      d = (i == 0) ? 16'hFFBE : 16'($urandom) & 16'hFFBE;
      bus(1'b1, 8'h1E, d);
      rchk(8'h1E, 16'hFFFF, cfg_exp(d));
      `CHK("duplex", d[11], ext_full_duplex)
      `CHK("mdix", d[9:8], {robust_mdix, fast_mdix})
      `CHK("pad_oe_n", !d[7], pad_oe_n)
    end
    $display("done: config fields");
    bus(1'b1, 8'h31, 16'h0003);
    bus(1'b1, 8'h30, 16'h0007);
    bus(1'b1, 8'h1E, 16'h00C0);
    cyc(3);
    `CHK("irq forced", 1'b1, irq)
    `CHK("pad_out forced", 1'b0, pad_out)
    `CHK("pad_oe_n driven", 1'b0, pad_oe_n)
    bus(1'b1, 8'h1E, 16'h0000);
    cyc(3);
    `CHK("irq unforced", 1'b0, irq)
    `CHK("pad_out idle", 1'b1, pad_out)
    pad_in <= 1'b0;
    cyc(5);
    `CHK("power_down", 1'b1, power_down)
    pad_in <= 1'b1;
    event_irq <= 1'b1;
    cyc(5);
    event_irq <= 1'b0;
    `CHK("power_down", 1'b0, power_down)
    rchk(8'h30, 16'h0004, 16'h0004);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, 8'h30, 16'h0004);
    bus(1'b1, 8'h31, 16'h0000);
    $display("done: pad and forced interrupt");
    // failing test then passing test: fail must show only the latest
    for (int i = 0; i < 2; i++) begin
      f = (i == 0);
      bus(1'b1, 8'h1E, 16'h0001);
      rchk(8'h1E, 16'h0002, 16'h0000);
      `CHK("engine_run", 1'b1, engine_run)
      engine_fail <= f;
      engine_done <= 1'b1;
      cyc(1);
      engine_done <= 1'b0;
      cyc(3);
      rchk(8'h1E, 16'h0006, {13'h0, f, 2'b10});
    end
    bus(1'b1, 8'h31, 16'h0006);
    cyc(3);
    `CHK("irq unmasked", 1'b1, irq)
    bus(1'b1, 8'h30, 16'h0007);
    cyc(3);
    `CHK("irq cleared", 1'b0, irq)
    $display("done: cable test and interrupt");
    for (int v = 0; v < 8; v++) begin
      bus(1'b1, 8'h25, {8'h04, 3'(v), 5'h0});
      rchk(8'h25, 16'hFFFF, {8'h04, 3'(v), 5'h0});
      `CHK("channels", chan_exp(3'(v)), test_chan_enable)
    end
    $display("done: test channels");
    bus(1'b1, 8'h1E, 16'h0300);
    bus(1'b1, 8'h1F, 16'h4000);
    cyc(2);
    `CHK("op_reset on", 1'b1, op_reset)
    cyc(12);
    `CHK("op_reset off", 1'b0, op_reset)
    rchk(8'h1F, 16'hFFFF, 16'h0000);
    rchk(8'h1E, 16'hFFC0, 16'h0300);
    bus(1'b1, 8'h25, 16'h04E0);
    bus(1'b1, 8'h1F, 16'h9FFF);
    cyc(3);
    rchk(8'h1E, 16'hFFFF, 16'h0002);
    rchk(8'h1F, 16'hFFFF, 16'h0000);
    rchk(8'h25, 16'hFFFF, 16'h0400);
    $display("done: restart and full reset");
    bus(1'b1, 8'h40, 16'hFFFF);
    bus(1'b0, 8'h40, 16'h0000);
    `CHK("unmapped response", 2'b11, rsp)
    `CHK("unmapped data", 32'h0, rd)
    $display("done: unmapped access");
    complete_run;
  end
endmodule // pccr_regs_tb
